// file: rtl/stop_release_snooze_control.v
`timescale 1ns/10ps
`include "stop_snooze_defs.vh"

// Functional notes
// - unmasked interrupt ends STOP, vector or continue
// - fast clocks stay stopped 18 to 65 us
// - fast clocks wait 7 or 1 clocks
// - crystal stop up to max(65us, stabilisation)
// - crystal waits 10-11 or 4-5 clocks
// - reset ends STOP, runs from reset vector
// - snooze only serial, uart, transfer, adc
// - snooze only on internal fast oscillator
// - transfer activation moves STOP into SNOOZE
// - STOP to SNOOZE takes 18 to 65 us
// - high-speed snooze exit 4.99-9.44us plus wait
// - low-speed snooze exit 1.10-5.08us plus wait
// - snooze gates cpu, starts fast oscillator
// - low-speed oscillator per timer/watchdog bits going to, in and leaving snooze; always on in STOP
module stop_release_snooze_control #(
   parameter STOP_CYC = `STOP_MIN_CYC,
   parameter CW = 16
) (
   // clock and reset
   input wire clk_in,
   input wire arst_n_in,
   // cpu side
   input wire stop_req_in,
   input wire irq_unmasked_in,
   input wire irq_ack_en_in,
   input wire [1:0] cpu_clk_src_in,
   input wire low_speed_main_mode_in,
   input wire [CW-1:0] osc_stabilize_time_select_in,
   // snooze sources and options
   input wire serial_snooze_wake_ctl_in,
   input wire uart_snooze_wake_ctl_in,
   input wire adc_snooze_wake_ctl_in,
   input wire xfer_act_en_in,
   input wire [3:0] snooze_trig_in,
   input wire interval_timer_clock_select_in,
   input wire watchdog_enable_option_in,
   input wire watchdog_standby_keep_in,
   // status and clock control
   output reg in_stop_out,
   output reg in_snooze_out,
   output reg cpu_clk_en_out,
   output reg vector_irq_out,
   output reg resume_next_out,
   output reg hioco_en_out,
   output reg main_clk_en_out,
   output reg loco_en_out
);
   localparam ST_RUN = 3'd0;
   localparam ST_STOP = 3'd1;
   localparam ST_WAKE = 3'd2;
   localparam ST_WAIT = 3'd3;
   localparam ST_TOSNZ = 3'd4;
   localparam ST_SNZ = 3'd5;
   localparam ST_SNZX = 3'd6;

   // load values cut to the timer width on purpose; cw must hold the longest count
   localparam [CW-1:0] STOP_LD = STOP_CYC[CW-1:0];
   localparam integer FAST_EXIT_I = `HIGH_MAIN_EXIT_CYC;
   localparam integer SLOW_EXIT_I = `LOW_MAIN_EXIT_CYC;
   localparam [CW-1:0] FAST_EXIT_LD = FAST_EXIT_I[CW-1:0];
   localparam [CW-1:0] SLOW_EXIT_LD = SLOW_EXIT_I[CW-1:0];

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] wait_r;
   reg vec_r;
   reg [1:0] irq_sync_r;
   reg [3:0] trig_s1_r;
   reg [3:0] trig_s2_r;
   reg load;
   reg [CW-1:0] load_val;
   wire tmr_done;
   wire [3:0] snz_allow;
   wire snz_hit;

   ////////////////////////////////////////////////////////////////////
   function [3:0] post_wait;
      input [1:0] src;
      input vec;
      begin
         if (src == `SRC_XTAL)
            post_wait = vec ? `WAIT_VEC_XTAL : `WAIT_NOVEC_XTAL;
         else
            post_wait = vec ? `WAIT_VEC_FAST : `WAIT_NOVEC_FAST;
      end
   endfunction

   stop_delay_timer #(.CW(CW)) u_tmr (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .load_in(load),
      .count_in(load_val),
      .done_out(tmr_done)
   );

   // interrupt and peripheral triggers arrive from other clocks
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_sync_r <= 2'b00;
         trig_s1_r <= 4'h0;
         trig_s2_r <= 4'h0;
      end else begin
         irq_sync_r <= {irq_sync_r[0], irq_unmasked_in};
         trig_s1_r <= snooze_trig_in;
         trig_s2_r <= trig_s1_r;
      end
   end

   assign snz_allow = (cpu_clk_src_in == `SRC_HIOCO) ?
      {adc_snooze_wake_ctl_in, xfer_act_en_in, uart_snooze_wake_ctl_in,
       serial_snooze_wake_ctl_in} : 4'h0;
   assign snz_hit = |(trig_s2_r & snz_allow);

   ////////////////////////////////////////////////////////////////////
   always @* begin
      state_nxt = state_r;
      load = 1'b0;
      load_val = STOP_LD;
      case (state_r)
         ST_RUN: begin
            if (stop_req_in)
               state_nxt = ST_STOP;
         end
         ST_STOP: begin
            if (irq_sync_r[1]) begin
               state_nxt = ST_WAKE;
               load = 1'b1;
               if (cpu_clk_src_in == `SRC_XTAL && osc_stabilize_time_select_in > STOP_LD)
                  load_val = osc_stabilize_time_select_in;
            end else if (snz_hit) begin
               state_nxt = ST_TOSNZ;
               load = 1'b1;
            end
         end
         ST_WAKE: begin
            if (tmr_done)
               state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (wait_r == 4'd0)
               state_nxt = ST_RUN;
         end
         ST_TOSNZ: begin
            if (tmr_done)
               state_nxt = ST_SNZ;
         end
         ST_SNZ: begin
            // interrupt wins over a pending trigger
            if (irq_sync_r[1]) begin
               state_nxt = ST_SNZX;
               load = 1'b1;
               load_val = low_speed_main_mode_in ? SLOW_EXIT_LD : FAST_EXIT_LD;
            end else if (!(|(trig_s2_r & snz_allow)))
               state_nxt = ST_STOP;
         end
         ST_SNZX: begin
            if (tmr_done)
               state_nxt = ST_WAIT;
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // reset ends stop
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= ST_RUN;
         wait_r <= 4'd0;
         vec_r <= 1'b0;
         in_stop_out <= 1'b0;
         in_snooze_out <= 1'b0;
         cpu_clk_en_out <= 1'b1;
         vector_irq_out <= 1'b0;
         resume_next_out <= 1'b0;
         hioco_en_out <= 1'b1;
         main_clk_en_out <= 1'b1;
         loco_en_out <= 1'b1;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_STOP || state_r == ST_SNZ)
            vec_r <= irq_ack_en_in;
         if (state_nxt == ST_WAIT && state_r != ST_WAIT)
            wait_r <= post_wait(cpu_clk_src_in, vec_r) - 4'd1;
         else if (wait_r != 4'd0)
            wait_r <= wait_r - 4'd1;
         in_stop_out <= (state_nxt == ST_STOP) || (state_nxt == ST_WAKE) ||
                        (state_nxt == ST_TOSNZ);
         in_snooze_out <= (state_nxt == ST_SNZ) || (state_nxt == ST_SNZX);
         cpu_clk_en_out <= (state_nxt == ST_RUN);
         hioco_en_out <= (state_nxt == ST_RUN) || (state_nxt == ST_WAIT) ||
                         (state_nxt == ST_SNZ) || (state_nxt == ST_SNZX);
         main_clk_en_out <= (state_nxt == ST_RUN) || (state_nxt == ST_WAIT) ||
                            (state_nxt == ST_WAKE);
         vector_irq_out <= (state_r == ST_WAIT) && (wait_r == 4'd0) && vec_r;
         resume_next_out <= (state_r == ST_WAIT) && (wait_r == 4'd0) && !vec_r;
         if (state_nxt == ST_SNZ || state_nxt == ST_SNZX || state_nxt == ST_TOSNZ)
            loco_en_out <= interval_timer_clock_select_in ||
                           (watchdog_enable_option_in && watchdog_standby_keep_in);
         else
            loco_en_out <= 1'b1;
      end
   end
endmodule

// file: include/stop_snooze_defs.vh
`ifndef STOP_SNOOZE_DEFS_VH
`define STOP_SNOOZE_DEFS_VH

// clock rate in MHz (125 MHz, 8 ns period)
`define CLK_MHZ 125
// clock stop time after a STOP wake, ns
`define STOP_MIN_NS 18000
`define STOP_MAX_NS 65000
// least stop time in cycles, rounded up
`define STOP_MIN_CYC ((`STOP_MIN_NS * `CLK_MHZ + 999) / 1000)
// SNOOZE to normal, ns, high-speed and low-speed main modes
`define HIGH_MAIN_EXIT_MIN_NS 4990
`define HIGH_MAIN_EXIT_MAX_NS 9440
`define LOW_MAIN_EXIT_MIN_NS 1100
`define LOW_MAIN_EXIT_MAX_NS 5080
`define HIGH_MAIN_EXIT_CYC ((`HIGH_MAIN_EXIT_MIN_NS * `CLK_MHZ + 999) / 1000)
`define LOW_MAIN_EXIT_CYC ((`LOW_MAIN_EXIT_MIN_NS * `CLK_MHZ + 999) / 1000)
// post-restart waits in clocks
`define WAIT_VEC_FAST 4'h7
`define WAIT_NOVEC_FAST 4'h1
`define WAIT_VEC_XTAL 4'ha
`define WAIT_NOVEC_XTAL 4'h4
// cpu clock source codes
`define SRC_HIOCO 2'h0
`define SRC_EXTCLK 2'h1
`define SRC_XTAL 2'h2
// snooze source bit positions
`define SNZ_CSI 0
`define SNZ_UART 1
`define SNZ_XFER 2
`define SNZ_ADC 3

`endif

// file: rtl/stop_delay_timer.v
`timescale 1ns/10ps
`include "stop_snooze_defs.vh"

module stop_delay_timer #(
   parameter CW = 16
) (
   // clock and reset
   input wire clk_in,
   input wire arst_n_in,
   // control
   input wire load_in,
   input wire [CW-1:0] count_in,
   // status
   output reg done_out
);
   reg [CW-1:0] cnt_r;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= {CW{1'b0}};
         done_out <= 1'b0;
      end else if (load_in) begin
         cnt_r <= count_in;
         done_out <= 1'b0;
      end else if (cnt_r != {CW{1'b0}}) begin
         cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
         done_out <= (cnt_r == {{(CW-1){1'b0}}, 1'b1});
      end else begin
         done_out <= 1'b0;
      end
   end
endmodule

// file: test/irq_src_model.sv
`timescale 1ns/10ps
module irq_src_model (
   input wire clk_in,
   input wire fire_in,
   input wire done_in,
   output reg irq_out,
   output reg [15:0] lat_out
);
   initial irq_out = 1'b0;
   always @(posedge clk_in) begin
      if (done_in)
         irq_out <= 1'b0;
      else if (fire_in)
         irq_out <= 1'b1;
      if (fire_in && !irq_out)
         lat_out <= 16'h0000;
      else if (irq_out)
         lat_out <= lat_out + 16'h0001;
   end
endmodule

// file: test/srsc_chk_asserts.sv
`timescale 1ns/10ps
module srsc_chk #(parameter int STOP_CYC = 2250) (
   input wire clk_in, arst_n_in, irq_unmasked_in, irq_ack_en_in,
   input wire [1:0] cpu_clk_src_in,
   input wire in_stop_out, in_snooze_out, cpu_clk_en_out, vector_irq_out,
   input wire resume_next_out, hioco_en_out, main_clk_en_out
);
   localparam int V1 = STOP_CYC + 7;
   localparam int V2 = STOP_CYC + 18;
   localparam int R1 = STOP_CYC + 1;
   localparam int R2 = STOP_CYC + 12;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   snz_clocks_a: assert property (in_snooze_out |->
      !cpu_clk_en_out && hioco_en_out && !main_clk_en_out) else $error("snooze clocks wrong");
   one_pulse_a: assert property (!(vector_irq_out && resume_next_out))
      else $error("both wake pulses");
   vec_ack_a: assert property (vector_irq_out |-> irq_ack_en_in)
      else $error("vector without ack enable");
   res_noack_a: assert property (resume_next_out |-> !irq_ack_en_in)
      else $error("resume with ack enable");
   pulse_clk_a: assert property ((vector_irq_out || resume_next_out) |->
      cpu_clk_en_out ##1 !(vector_irq_out || resume_next_out)) else $error("wake pulse wrong");
   stop_gate_a: assert property ($rose(in_stop_out) && !in_snooze_out |->
      !cpu_clk_en_out [*8]) else $error("clock not held off");
   fast_vec_a: assert property ($rose(irq_unmasked_in) && in_stop_out && !in_snooze_out
      && cpu_clk_src_in != 2'h2 && irq_ack_en_in |-> ##[V1:V2] vector_irq_out)
      else $error("fast vector wake timing");
   fast_res_a: assert property ($rose(irq_unmasked_in) && in_stop_out && !in_snooze_out
      && cpu_clk_src_in != 2'h2 && !irq_ack_en_in |-> ##[R1:R2] resume_next_out)
      else $error("fast resume wake timing");
endmodule
bind stop_release_snooze_control srsc_chk #(.STOP_CYC(STOP_CYC)) srsc_chk_i (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .irq_unmasked_in(irq_unmasked_in),
   .irq_ack_en_in(irq_ack_en_in), .cpu_clk_src_in(cpu_clk_src_in),
   .in_stop_out(in_stop_out), .in_snooze_out(in_snooze_out),
   .cpu_clk_en_out(cpu_clk_en_out), .vector_irq_out(vector_irq_out),
   .resume_next_out(resume_next_out), .hioco_en_out(hioco_en_out),
   .main_clk_en_out(main_clk_en_out));

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   reg clk_in = 1'b0;
   reg arst_n_in = 1'b0;
   reg sreq = 1'b0, ack = 1'b0, lsm = 1'b0, fire = 1'b0;
   reg [1:0] src = 2'h0;
   reg [15:0] ost = 16'h0000;
   reg [3:0] en = 4'h0, trig = 4'h0;
   reg [2:0] lo = 3'h0;
   wire irq, stp, snz, cke, vec, res, hio, mck, loc;
   wire [15:0] lat;
   integer err_total = 0, total_checks = 0;
   always #4 clk_in = ~clk_in;
   stop_release_snooze_control #(.STOP_CYC(20)) stop_release_snooze_control_i (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .stop_req_in(sreq), .irq_unmasked_in(irq),
      .irq_ack_en_in(ack), .cpu_clk_src_in(src), .low_speed_main_mode_in(lsm),
      .osc_stabilize_time_select_in(ost), .serial_snooze_wake_ctl_in(en[0]),
      .uart_snooze_wake_ctl_in(en[1]), .adc_snooze_wake_ctl_in(en[3]),
      .xfer_act_en_in(en[2]), .snooze_trig_in(trig), .interval_timer_clock_select_in(lo[2]),
      .watchdog_enable_option_in(lo[1]), .watchdog_standby_keep_in(lo[0]),
      .in_stop_out(stp), .in_snooze_out(snz), .cpu_clk_en_out(cke), .vector_irq_out(vec),
      .resume_next_out(res), .hioco_en_out(hio), .main_clk_en_out(mck), .loco_en_out(loc));
   irq_src_model irq_src_model_i (.clk_in(clk_in), .fire_in(fire), .done_in(vec | res),
      .irq_out(irq), .lat_out(lat));
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
      begin
         total_checks = total_checks + 1;
         if (e !== g) begin
            err_total = err_total + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task stop_test;
      begin
         $display("mismatches %0d checks %0d", err_total, total_checks);
         if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge clk_in);
   endtask
   task enter_stop;
      begin
         sreq = 1'b1;
         cyc(1);
         sreq = 1'b0;
         cyc(2);
      end
   endtask
   // irq stays up in the model until a wake pulse, so its fall ends the wait
   task irq_wait;
      integer k;
      reg sv, sr;
      begin
         fire = 1'b1;
         cyc(1);
         fire = 1'b0;
         k = 0;
         sv = 1'b0;
         sr = 1'b0;
         while (irq !== 1'b0 && k < 3000) begin
            if (vec === 1'b1)
               sv = 1'b1;
            if (res === 1'b1)
               sr = 1'b1;
            cyc(1);
            k = k + 1;
         end
         cyc(3);
         chk("cpuclk", 1, cke);
         chk("wakekind", {ack, !ack}, {sv, sr});
      end
   endtask
   task wake(input a);
      begin
         ack = a;
         enter_stop;
         irq_wait;
      end
   endtask
   task t_fast;
      reg [15:0] lv;
      integer s;
      begin
         for (s = 0; s < 2; s = s + 1) begin
            src = s[1:0];
            wake(1'b1);
            lv = lat;
            wake(1'b0);
            chk("fastdiff", 16'h0006, lv - lat);
            chk("fastmin", 1, lat >= 16'h0015);
         end
      end
   endtask
   task t_xtal;
      reg [15:0] lv;
      begin
         src = 2'h2;
         ost = 16'h003c;
         wake(1'b1);
         lv = lat;
         wake(1'b0);
         chk("xtaldiff", 1, lv - lat >= 16'h0005 && lv - lat <= 16'h0007);
         chk("xtalmin", 1, lat >= 16'h003c);
         src = 2'h0;
      end
   endtask
   task t_snooze;
      integer i, k;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            en = 4'h1 << i;
            lsm = i[0];
            ack = i[1];
            enter_stop;
            trig = en;
            k = 0;
            while (snz !== 1'b1 && k < 100) begin
               cyc(1);
               k = k + 1;
            end
            chk("tosnz", 1, k >= 19 && k <= 26);
            chk("snzclk", 16'h0002, {cke, hio, mck});
            lo = i[2:0];
            cyc(2);
            chk("loco", i == 3, loc);
            lo = i[2:0] + 3'h4;
            cyc(2);
            chk("loco", 1, loc);
            irq_wait;
            chk("snzexit", 1, i % 2 ? lat >= 16'h008a && lat < 16'h0294
               : lat >= 16'h0270 && lat < 16'h04b0);
            trig = 4'h0;
         end
      end
   endtask
   task t_refuse;
      integer i;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            src = i[1:0];
            en = i == 0 ? 4'h0 : 4'hf;
            enter_stop;
            trig = 4'hf;
            cyc(30);
            chk("refused", 0, snz);
            trig = 4'h0;
            irq_wait;
         end
         src = 2'h0;
      end
   endtask
   task t_reset;
      begin
         enter_stop;
         chk("stop", 1, stp);
         arst_n_in = 1'b0;
         cyc(1);
         arst_n_in = 1'b1;
         cyc(1);
         chk("stop", 0, stp);
         chk("cpuclk", 1, cke);
      end
   endtask
   initial begin
      cyc(4);
      arst_n_in = 1'b1;
      cyc(1);
      t_fast;
      t_xtal;
      t_snooze;
      t_refuse;
      t_reset;
      stop_test;
   end
   initial begin
      #400000;
      err_total = err_total + 1;
      stop_test;
   end
endmodule
